// ### src/gpio_out_mux_defines.svh
/*
 * Register indices, field positions and reset values of the pin output
 * source multiplexer. Assumes a byte-addressed bus with word registers: byte address is four
 * times the index.
 */
`ifndef GPIO_OUT_MUX_DEFINES_SVH
`define GPIO_OUT_MUX_DEFINES_SVH

`define PIN3_CTL_IDX 8'h13
`define PIN4_CTL_IDX 8'h14
`define PORT_CFG_IDX 8'h20
`define PIN_STAT_IDX 8'h21

`define CTL_EN_BIT 0
`define CTL_VAL_BIT 1
`define CTL_SRC_LSB 2
`define CTL_SRC_MSB 4
`define CTL_SEL_LSB 5
`define CTL_SEL_MSB 7

`define CFG_RXEN_LSB 0
`define CFG_TX0_LSB 4
`define CFG_TX1_LSB 8

`define CTL_RST 8'h00
`define CFG_RST 12'h000

`endif

// ### src/gpio_out_mux_pkg.sv
/*
 * Types shared by the pin output source multiplexer.
 * Assumes nothing of its surroundings.
 */
package gpio_out_mux_pkg;

    typedef enum logic [2:0] {
        SRC_RX0 = 3'h0,
        SRC_RX1 = 3'h1,
        SRC_RX2 = 3'h2,
        SRC_RX3 = 3'h3,
        SRC_STATUS = 3'h4,
        SRC_RSVD = 3'h5,
        SRC_TX0 = 3'h6,
        SRC_TX1 = 3'h7
    } source_domain_e;

    typedef logic [7:0] pin_ctl_t;

endpackage

// ### src/gpio_output_source_mux.sv
/*
 * Output source selection for two general-purpose pins, with their control
 * registers and a port configuration register behind a classic Wishbone
 * slave. Assumes all status inputs are synchronous to CLK_SYS.
 */
`include "gpio_out_mux_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - source field bits 4:2 picks rx port 0-3, status, reserved, tx port 0-1.
// - selector field bits 7:5 picks the signal, meaning set by source.
// - rx source: 0xx remote pin, 100 lock, 101 pass, 110 frame, 111 line.
// - status source: 000 value bit, 001 OR of enabled locks, 010 AND.
// - status source selector 011 gives AND of pass across enabled ports.
// - tx source: one code gives the tx interrupt, 101 to 111 are reserved.
// - value bit 1 is the level driven when local value is selected.
// - next pin control register sits at 0x14, resets to 0x00.
module gpio_output_source_mux (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [9:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic [15:0] RX_REMOTE_PINS,
    input wire logic [3:0] RX_LOCK,
    input wire logic [3:0] RX_PASS,
    input wire logic [3:0] RX_FRAME_VALID,
    input wire logic [3:0] RX_LINE_VALID,
    input wire logic [1:0] TX_FRAME_VALID,
    input wire logic [1:0] TX_LINE_VALID,
    input wire logic [1:0] TX_INTERRUPT,
    output logic PIN3_OUT,
    output logic PIN3_OE_N,
    output logic PIN4_OUT,
    output logic PIN4_OE_N
);

    gpio_out_mux_pkg::pin_ctl_t ctl_q [2];
    gpio_out_mux_pkg::pin_ctl_t ctl_d [2];
    logic [11:0] cfg_q;
    logic [11:0] cfg_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic [1:0] out_q;
    logic [1:0] out_d;
    logic [1:0] oe_n_q;
    logic [1:0] oe_n_d;
    logic req;
    logic wr_now;
    logic [7:0] idx;
    logic aligned;

    // signal picked by one control byte; reserved codes yield 0
    function automatic logic pick(
        input gpio_out_mux_pkg::pin_ctl_t ctl,
        input logic [11:0] cfg,
        input logic [15:0] rpin,
        input logic [3:0] lock,
        input logic [3:0] pass,
        input logic [3:0] fv,
        input logic [3:0] lv,
        input logic [1:0] tfv,
        input logic [1:0] tlv,
        input logic [1:0] tint
    );
        gpio_out_mux_pkg::source_domain_e src;
        logic [2:0] sel;
        logic [1:0] p;
        logic t;
        logic [3:0] en;
        logic [3:0] m;
        logic r;
        src = gpio_out_mux_pkg::source_domain_e'(ctl[`CTL_SRC_MSB:`CTL_SRC_LSB]);
        sel = ctl[`CTL_SEL_MSB:`CTL_SEL_LSB];
        p = src[1:0];
        t = src[0];
        en = cfg[`CFG_RXEN_LSB +: 4];
        m = t ? cfg[`CFG_TX1_LSB +: 4] : cfg[`CFG_TX0_LSB +: 4];
        r = 1'b0;
        case (src)
            gpio_out_mux_pkg::SRC_RX0,
            gpio_out_mux_pkg::SRC_RX1,
            gpio_out_mux_pkg::SRC_RX2,
            gpio_out_mux_pkg::SRC_RX3: begin
                case (sel)
                    3'h4: r = lock[p];
                    3'h5: r = pass[p];
                    3'h6: r = fv[p];
                    3'h7: r = lv[p];
                    default: r = rpin[{p, sel[1:0]}];
                endcase
            end
            gpio_out_mux_pkg::SRC_STATUS: begin
                case (sel)
                    3'h0: r = ctl[`CTL_VAL_BIT];
                    3'h1: r = |(lock & en);
                    // no enabled port means no AND indication
                    3'h2: r = (|en) & (&(lock | ~en));
                    3'h3: r = (|en) & (&(pass | ~en));
                    default: r = 1'b0;
                endcase
            end
            gpio_out_mux_pkg::SRC_TX0,
            gpio_out_mux_pkg::SRC_TX1: begin
                case (sel)
                    3'h0: r = (|m) & (&(pass | ~m));
                    3'h1: r = |(pass & m);
                    3'h2: r = tfv[t];
                    3'h3: r = tlv[t] & tfv[t];
                    3'h4: r = tint[t];
                    default: r = 1'b0;
                endcase
            end
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign req = CYC_I & STB_I;
    assign idx = ADR_I[9:2];
    assign aligned = (ADR_I[1:0] == 2'h0);
    // writes land on the edge where the master sees ack
    assign wr_now = req & WE_I & ack_q & aligned;

    always_comb begin
        ack_d = req & ~ack_q;
        dat_d = dat_q;
        if (req & ~ack_q) begin
            dat_d = 32'h0000_0000;
            if (aligned) begin
                case (idx)
                    `PIN3_CTL_IDX: dat_d[7:0] = ctl_q[0];
                    `PIN4_CTL_IDX: dat_d[7:0] = ctl_q[1];
                    `PORT_CFG_IDX: dat_d[11:0] = cfg_q;
                    `PIN_STAT_IDX: dat_d[3:0] = {oe_n_q, out_q};
                    default: dat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    always_comb begin
        ctl_d[0] = ctl_q[0];
        ctl_d[1] = ctl_q[1];
        cfg_d = cfg_q;
        if (wr_now) begin
            if (idx == `PIN3_CTL_IDX && SEL_I[0]) begin
                ctl_d[0] = DAT_I[7:0];
            end
            if (idx == `PIN4_CTL_IDX && SEL_I[0]) begin
                ctl_d[1] = DAT_I[7:0];
            end
            if (idx == `PORT_CFG_IDX) begin
                if (SEL_I[0]) begin
                    cfg_d[7:0] = DAT_I[7:0];
                end
                if (SEL_I[1]) begin
                    cfg_d[11:8] = DAT_I[11:8];
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctl_q[0] <= `CTL_RST;
            ctl_q[1] <= `CTL_RST;
            cfg_q <= `CFG_RST;
        end else begin
            ctl_q[0] <= ctl_d[0];
            ctl_q[1] <= ctl_d[1];
            cfg_q <= cfg_d;
        end
    end

    // pin level is forced low while released so the pad never floats a stale level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            oe_n_d[i] = ~ctl_q[i][`CTL_EN_BIT];
            out_d[i] = ctl_q[i][`CTL_EN_BIT] & pick(ctl_q[i], cfg_q, RX_REMOTE_PINS, RX_LOCK, RX_PASS,
                RX_FRAME_VALID, RX_LINE_VALID, TX_FRAME_VALID, TX_LINE_VALID, TX_INTERRUPT);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            out_q <= 2'h0;
            oe_n_q <= 2'h3;
        end else begin
            out_q <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign PIN3_OUT = out_q[0];
    assign PIN4_OUT = out_q[1];
    assign PIN3_OE_N = oe_n_q[0];
    assign PIN4_OE_N = oe_n_q[1];

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    logic [2:0] src3;
    logic [2:0] sel3;
    logic en3;
    assign src3 = ctl_q[0][`CTL_SRC_MSB:`CTL_SRC_LSB];
    assign sel3 = ctl_q[0][`CTL_SEL_MSB:`CTL_SEL_LSB];
    assign en3 = ctl_q[0][`CTL_EN_BIT];

    sequence wr_pin3_s;
        CYC_I && STB_I && WE_I && ACK_O && ADR_I == 10'h04C && SEL_I[0];
    endsequence

    sequence wr_pin4_s;
        CYC_I && STB_I && WE_I && ACK_O && ADR_I == 10'h050 && SEL_I[0];
    endsequence

    enable_drive_a: assert property (wr_pin3_s |-> ##2 (PIN3_OE_N == !$past(DAT_I[0], 2)))
        else $error("pin3 drive enable does not follow written bit 0");

    released_low_a: assert property (!en3 |=> (PIN3_OE_N && !PIN3_OUT))
        else $error("released pin3 is not low");

    pin4_write_a: assert property (wr_pin4_s |=> (ctl_q[1] == $past(DAT_I[7:0])))
        else $error("pin4 control write at 0x14 not stored");

    pin4_reset_a: assert property (!$past(RST_N) |-> (ctl_q[1] == 8'h00 && PIN4_OE_N))
        else $error("pin4 control not cleared after reset");

    reserved_src_a: assert property ((src3 == 3'h5) |=> !PIN3_OUT)
        else $error("reserved source drives pin3 high");

    remote_pin_a: assert property ((en3 && !src3[2] && !sel3[2])
        |=> PIN3_OUT == $past(RX_REMOTE_PINS[{src3[1:0], sel3[1:0]}]))
        else $error("pin3 does not show the remote pin");

    rx_lock_a: assert property ((en3 && !src3[2] && sel3 == 3'h4)
        |=> PIN3_OUT == $past(RX_LOCK[src3[1:0]]))
        else $error("pin3 does not show port lock");

    local_value_a: assert property ((en3 && src3 == 3'h4 && sel3 == 3'h0)
        |=> PIN3_OUT == $past(ctl_q[0][1]))
        else $error("pin3 does not show its value bit");

    any_lock_a: assert property ((en3 && src3 == 3'h4 && sel3 == 3'h1)
        |=> PIN3_OUT == $past(|(RX_LOCK & cfg_q[3:0])))
        else $error("pin3 is not the OR of enabled locks");

    all_pass_a: assert property ((en3 && src3 == 3'h4 && sel3 == 3'h3 && cfg_q[3:0] == 4'hF)
        |=> PIN3_OUT == $past(&RX_PASS))
        else $error("pin3 is not the AND of enabled pass");

    tx_line_a: assert property ((en3 && src3 == 3'h6 && sel3 == 3'h3)
        |=> PIN3_OUT == $past(TX_LINE_VALID[0] & TX_FRAME_VALID[0]))
        else $error("pin3 is not tx0 line valid in frame");

    tx_irq_a: assert property ((en3 && src3 == 3'h7 && sel3 == 3'h4)
        |=> PIN3_OUT == $past(TX_INTERRUPT[1]))
        else $error("pin3 is not tx1 interrupt");

    tx_rsvd_a: assert property ((src3[2:1] == 2'h3 && sel3 == 3'h7) |=> !PIN3_OUT)
        else $error("reserved tx selector drives pin3 high");

    all_lock_a: assert property ((en3 && src3 == 3'h4 && sel3 == 3'h2 && cfg_q[3:0] == 4'h5)
        |=> PIN3_OUT == $past(RX_LOCK[0] & RX_LOCK[2]))
        else $error("pin3 is not the AND of enabled locks");

    status_rsvd_a: assert property ((src3 == 3'h4 && sel3[2]) |=> !PIN3_OUT)
        else $error("reserved status selector drives pin3 high");

    tx_any_pass_a: assert property ((en3 && src3 == 3'h6 && sel3 == 3'h1 && cfg_q[7:4] == 4'h3)
        |=> PIN3_OUT == $past(RX_PASS[0] | RX_PASS[1]))
        else $error("pin3 is not the OR of tx0 selected pass");

    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack held for more than one cycle");

endmodule

`default_nettype wire

// ### verification/pin_observer.sv
/*
 * Board-side observer of one general-purpose pin: resolves the wire level.
 * Assumes the net has no pull, so a released pin must not look held.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_observer (
    input wire logic clk,
    input wire logic drive,
    input wire logic oe_n,
    output logic level
);
    logic last_q;
    // undriven net toggles so a stale level can never pass for a driven one
    always_ff @(posedge clk) last_q <= oe_n ? ~last_q : drive;
    assign level = oe_n ? ~last_q : drive;
endmodule
`default_nettype wire

// ### verification/gpio_output_source_mux_tb.sv
/*
 * Self-checking bench for the pin output source multiplexer.
 * Assumes a classic Wishbone slave and pins that follow their inputs in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_output_source_mux_tb;
    logic CLK_SYS = 1'b0, RST_N = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
    logic [9:0] ADR_I = '0;
    logic [3:0] SEL_I = '0, RX_LOCK = '0, RX_PASS = '0, RX_FRAME_VALID = '0, RX_LINE_VALID = '0;
    logic [31:0] DAT_I = '0;
    logic [15:0] RX_REMOTE_PINS = '0;
    logic [1:0] TX_FRAME_VALID = '0, TX_LINE_VALID = '0, TX_INTERRUPT = '0;
    logic [31:0] DAT_O, rd;
    logic ACK_O, PIN3_OUT, PIN3_OE_N, PIN4_OUT, PIN4_OE_N, lvl3, lvl4;
    int fails = 0, compares = 0, cycles = 0;

    always #2.5 CLK_SYS = ~CLK_SYS;

    gpio_output_source_mux dut (.CLK_SYS, .RST_N, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
        .RX_REMOTE_PINS, .RX_LOCK, .RX_PASS, .RX_FRAME_VALID, .RX_LINE_VALID, .TX_FRAME_VALID, .TX_LINE_VALID,
        .TX_INTERRUPT, .PIN3_OUT, .PIN3_OE_N, .PIN4_OUT, .PIN4_OE_N);
    pin_observer obs3 (.clk(CLK_SYS), .drive(PIN3_OUT), .oe_n(PIN3_OE_N), .level(lvl3));
    pin_observer obs4 (.clk(CLK_SYS), .drive(PIN4_OUT), .oe_n(PIN4_OE_N), .level(lvl4));

    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLK_SYS);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= {idx, 2'h0};
        SEL_I <= 4'hF;
        DAT_I <= d;
        do @(posedge CLK_SYS); while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
    endtask

    // drive status, program pin3, then look at the resolved wire level
    task automatic go(input logic [7:0] c, input logic [3:0] lk, ps, input logic [1:0] tf, tl, ti, input logic exp);
        @(posedge CLK_SYS);
        RX_LOCK <= lk;
        RX_PASS <= ps;
        TX_FRAME_VALID <= tf;
        TX_LINE_VALID <= tl;
        TX_INTERRUPT <= ti;
        wb(1'b1, 8'h13, {24'h0, c}, rd);
        repeat (2) @(posedge CLK_SYS);
        #1;
        chk("pin3_oe_n", 32'h0, PIN3_OE_N);
        chk("pin3_level", exp, lvl3);
    endtask

    task automatic t_reset_local;
        wb(1'b0, 8'h13, 32'h0, rd);
        chk("pin3_ctl", 32'h0, rd);
        wb(1'b0, 8'h14, 32'h0, rd);
        chk("pin4_ctl", 32'h0, rd);
        chk("pin3_oe_n", 32'h1, PIN3_OE_N);
        go(8'h13, 4'hF, 4'hF, 2'h3, 2'h3, 2'h3, 1'b1);
        go(8'h11, 4'hF, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
        wb(1'b1, 8'h13, 32'h12, rd);
        repeat (2) @(posedge CLK_SYS);
        #1;
        chk("pin3_oe_n", 32'h1, PIN3_OE_N);
        chk("pin3_out", 32'h0, PIN3_OUT);
    endtask

    task automatic t_rx;
        logic [15:0] rp;
        logic [3:0] lk, ps, fv, lv;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 8; s++) begin
                rp = (s < 4) ? 16'h1 << (p * 4 + s) : 16'h0;
                lk = (s == 4) ? 4'h1 << p : 4'h0;
                ps = (s == 5) ? 4'h1 << p : 4'h0;
                fv = (s == 6) ? 4'h1 << p : 4'h0;
                lv = (s == 7) ? 4'h1 << p : 4'h0;
                @(posedge CLK_SYS);
                RX_REMOTE_PINS <= rp;
                RX_FRAME_VALID <= fv;
                RX_LINE_VALID <= lv;
                go({s[2:0], p[2:0], 2'h1}, lk, ps, 2'h0, 2'h0, 2'h0, 1'b1);
                @(posedge CLK_SYS);
                RX_REMOTE_PINS <= ~rp;
                RX_FRAME_VALID <= ~fv;
                RX_LINE_VALID <= ~lv;
                go({s[2:0], p[2:0], 2'h1}, ~lk, ~ps, 2'h3, 2'h3, 2'h3, 1'b0);
            end
        end
    endtask

    task automatic t_status_tx;
        wb(1'b1, 8'h20, 32'hC35, rd);
        wb(1'b0, 8'h20, 32'h0, rd);
        chk("port_cfg", 32'hC35, rd);
        go(8'h31, 4'h1, 4'h0, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h31, 4'hA, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h51, 4'hF, 4'h0, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h51, 4'h1, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h71, 4'h0, 4'h5, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h71, 4'hF, 4'h4, 2'h3, 2'h3, 2'h3, 1'b0);
        wb(1'b1, 8'h20, 32'hC3F, rd);
        go(8'h71, 4'h0, 4'hF, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h71, 4'hF, 4'h7, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h91, 4'hF, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h17, 4'hF, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h19, 4'h0, 4'h3, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h19, 4'hF, 4'hE, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h39, 4'h0, 4'h2, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h39, 4'hF, 4'hC, 2'h3, 2'h3, 2'h3, 1'b0);
        go(8'h1D, 4'h0, 4'hC, 2'h0, 2'h0, 2'h0, 1'b1);
        go(8'h59, 4'h0, 4'h0, 2'h1, 2'h0, 2'h0, 1'b1);
        go(8'h59, 4'hF, 4'hF, 2'h2, 2'h3, 2'h3, 1'b0);
        go(8'h79, 4'h0, 4'h0, 2'h1, 2'h1, 2'h0, 1'b1);
        go(8'h79, 4'hF, 4'hF, 2'h2, 2'h3, 2'h3, 1'b0);
        go(8'h99, 4'h0, 4'h0, 2'h0, 2'h0, 2'h1, 1'b1);
        go(8'h9D, 4'hF, 4'hF, 2'h3, 2'h3, 2'h1, 1'b0);
        for (int s = 5; s < 8; s++)
            go({s[2:0], 5'h19}, 4'hF, 4'hF, 2'h3, 2'h3, 2'h3, 1'b0);
    endtask

    task automatic t_pin4_map;
        wb(1'b1, 8'h14, 32'h13, rd);
        wb(1'b1, 8'h30, 32'hFF, rd);
        wb(1'b0, 8'h30, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, 8'h14, 32'h0, rd);
        chk("pin4_ctl", 32'h13, rd);
        wb(1'b0, 8'h21, 32'h0, rd);
        chk("pin_stat", 32'h2, rd);
        #1;
        chk("pin4_oe_n", 32'h0, PIN4_OE_N);
        chk("pin4_level", 32'h1, lvl4);
    endtask

    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        t_reset_local();
        t_rx();
        t_status_tx();
        t_pin4_map();
        print_verdict();
    end
endmodule
`default_nettype wire
